//--- inc/burst_sram_consts.vh
// Constants for the pipelined burst SRAM access block
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
`define ADDR_W        17
`define DATA_W        36
`define LANES         4
`define LANE_W        9
`define FIFO_DEPTH    16
`define FIFO_AW       4
`define PIPE_DEPTH    2
`define BURST_LEN     4
`define ADDR_RST      17'h0_0000
`define DATA_RST      36'h0_0000_0000
`define LANE_RST      4'hF
`define BCNT_RST      2'h0
`endif

//--- core/burst_sram_access.v
// Access pipeline of a pipelined burst SRAM with a write data FIFO
// Notes on behaviour
// - In a burst the two low address bits step through four words, linear or interleaved by burst_order_select.
// - Sampling advance_or_load_select low ends any burst and loads new address and control.
// - While advance_or_load_select is high the read/write input is ignored and the direction is kept.
// - A load with read/write low starts a write, otherwise a read.
// - Byte lane selects are taken two cycles before their matching write data.
// - With clock_suspend_n high at an edge, all state behind the input synchronisers holds two edges later, as if that edge never came.
// - The device is selected only with both low selects low and the high select high.
`timescale 1ns/1ps
`include "burst_sram_consts.vh"

module write_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q < DEPTH);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module burst_sram_access (
    input  wire                 sys_clk,
    input  wire                 rst_n,
    input  wire                 clock_suspend_n,
    input  wire                 advance_or_load_select,
    input  wire                 read_write_n,
    input  wire                 chip_select_first_n,
    input  wire                 chip_select_second_n,
    input  wire                 chip_select_positive,
    input  wire                 burst_order_select,
    input  wire [`ADDR_W-1:0]   address,
    input  wire [`LANES-1:0]    byte_lane_write_n,
    input  wire [`DATA_W-1:0]   data_in,
    input  wire                 wdata_valid,
    output reg                  wdata_ready,
    output reg  [`DATA_W-1:0]   data_out,
    output reg                  data_oe_n,
    output reg                  mem_write,
    output reg  [`ADDR_W-1:0]   mem_addr,
    output reg  [`DATA_W-1:0]   mem_wdata,
    output reg  [`LANES-1:0]    mem_lane_write
);
    // Two-flop synchronisers for every pin input except rst_n
    reg                 cen_s1_q;
    reg                 cen_q;
    reg                 adv_s1_q;
    reg                 adv_q;
    reg                 rw_s1_q;
    reg                 rw_q;
    reg                 cs1_s1_q;
    reg                 cs1_q;
    reg                 cs2_s1_q;
    reg                 cs2_q;
    reg                 csp_s1_q;
    reg                 csp_q;
    reg                 ord_s1_q;
    reg                 ord_q;
    reg [`ADDR_W-1:0]   a_s1_q;
    reg [`ADDR_W-1:0]   a_q;
    reg [`LANES-1:0]    bw_s1_q;
    reg [`LANES-1:0]    bw_q;
    reg [`DATA_W-1:0]   d_s1_q;
    reg [`DATA_W-1:0]   d_q;
    reg                 dv_s1_q;
    reg                 dv_q;
    // Access state
    reg [`ADDR_W-1:0]   base_q;
    reg [1:0]           bcnt_q;
    reg                 act_q;
    reg                 wr_q;
    reg                 ord_lat_q;
    // Pipeline: stage 1 reads the array, stage 3 meets its write data
    reg                 p1_v_q;
    reg                 p1_w_q;
    reg [`ADDR_W-1:0]   p1_a_q;
    reg [`LANES-1:0]    p1_bw_q;
    reg                 p2_v_q;
    reg                 p2_w_q;
    reg [`ADDR_W-1:0]   p2_a_q;
    reg [`LANES-1:0]    p2_bw_q;
    reg                 p3_v_q;
    reg                 p3_w_q;
    reg [`ADDR_W-1:0]   p3_a_q;
    reg [`LANES-1:0]    p3_bw_q;
    reg [`DATA_W-1:0]   p3_d_q;
    // Only 256 words kept, upper address bits alias
    reg [`DATA_W-1:0]   mem [0:255];

    wire                run;
    wire                sel;
    wire                load;
    wire                cyc_v;
    wire                cyc_w;
    wire [`ADDR_W-1:0]  cyc_a;
    wire [1:0]          nxt_cnt;
    wire [`DATA_W-1:0]  fifo_data;
    wire                fifo_valid;
    wire                fifo_ready_w;
    wire                fifo_pop;
    wire                wbeat;
    wire [`DATA_W-1:0]  wdat;

    function [1:0] burst_low;
        input [1:0] start;
        input [1:0] step;
        input       linear;
        begin
            if (linear) begin
                burst_low = start + step;
            end else begin
                burst_low = start ^ step;
            end
        end
    endfunction

    function [`DATA_W-1:0] lane_merge;
        input [`DATA_W-1:0] old_w;
        input [`DATA_W-1:0] new_w;
        input [`LANES-1:0]  en;
        integer i;
        begin
            lane_merge = old_w;
            for (i = 0; i < `LANES; i = i + 1) begin
                if (en[i]) begin
                    lane_merge[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
                end
            end
        end
    endfunction

    assign run     = ~cen_q;
    assign sel     = ~cs1_q & ~cs2_q & csp_q;
    assign load    = ~adv_q;
    assign nxt_cnt = bcnt_q + 2'h1;
    // Burst order low = linear, high = interleaved
    assign cyc_v   = load ? sel : act_q;
    assign cyc_w   = load ? ~rw_q : wr_q;
    assign cyc_a   = load ? a_q
                   : {base_q[`ADDR_W-1:2], burst_low(base_q[1:0], nxt_cnt, ~ord_lat_q)};
    // Data pushed at stage 2 is the FIFO head when its beat reaches stage 3
    // Popping one stage later keeps every beat paired with its own word
    assign wbeat    = run & p3_v_q & p3_w_q;
    assign fifo_pop = wbeat;
    // Staged word is used only if the controller sent no data
    assign wdat     = fifo_valid ? fifo_data : p3_d_q;

    write_fifo #(
        .WIDTH (`DATA_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (dv_q & run),
        .in_ready  (fifo_ready_w),
        .in_data   (d_q),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    always @(posedge sys_clk) begin
        cen_s1_q <= clock_suspend_n;
        cen_q    <= cen_s1_q;
        adv_s1_q <= advance_or_load_select;
        adv_q    <= adv_s1_q;
        rw_s1_q  <= read_write_n;
        rw_q     <= rw_s1_q;
        cs1_s1_q <= chip_select_first_n;
        cs1_q    <= cs1_s1_q;
        cs2_s1_q <= chip_select_second_n;
        cs2_q    <= cs2_s1_q;
        csp_s1_q <= chip_select_positive;
        csp_q    <= csp_s1_q;
        ord_s1_q <= burst_order_select;
        ord_q    <= ord_s1_q;
        a_s1_q   <= address;
        a_q      <= a_s1_q;
        bw_s1_q  <= byte_lane_write_n;
        bw_q     <= bw_s1_q;
        d_s1_q   <= data_in;
        d_q      <= d_s1_q;
        dv_s1_q  <= wdata_valid;
        dv_q     <= dv_s1_q;
    end

    // Array write happens on stage 3 with data arriving two cycles after lanes
    always @(posedge sys_clk) begin
        if (wbeat) begin
            mem[p3_a_q[7:0]] <= lane_merge(mem[p3_a_q[7:0]], wdat, ~p3_bw_q);
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            base_q         <= `ADDR_RST;
            bcnt_q         <= `BCNT_RST;
            act_q          <= 1'b0;
            wr_q           <= 1'b0;
            ord_lat_q      <= 1'b0;
            p1_v_q         <= 1'b0;
            p1_w_q         <= 1'b0;
            p1_a_q         <= `ADDR_RST;
            p1_bw_q        <= `LANE_RST;
            p2_v_q         <= 1'b0;
            p2_w_q         <= 1'b0;
            p2_a_q         <= `ADDR_RST;
            p2_bw_q        <= `LANE_RST;
            p3_v_q         <= 1'b0;
            p3_w_q         <= 1'b0;
            p3_a_q         <= `ADDR_RST;
            p3_bw_q        <= `LANE_RST;
            p3_d_q         <= `DATA_RST;
            data_out       <= `DATA_RST;
            data_oe_n      <= 1'b1;
            mem_write      <= 1'b0;
            mem_addr       <= `ADDR_RST;
            mem_wdata      <= `DATA_RST;
            mem_lane_write <= 4'h0;
            wdata_ready    <= 1'b1;
        end else if (run) begin
            if (load) begin
                base_q    <= a_q;
                bcnt_q    <= `BCNT_RST;
                act_q     <= sel;
                wr_q      <= ~rw_q;
                ord_lat_q <= ord_q;
            end else begin
                bcnt_q <= nxt_cnt;
            end
            p1_v_q  <= cyc_v;
            p1_w_q  <= cyc_w;
            p1_a_q  <= cyc_a;
            p1_bw_q <= bw_q;
            p2_v_q  <= p1_v_q;
            p2_w_q  <= p1_w_q;
            p2_a_q  <= p1_a_q;
            p2_bw_q <= p1_bw_q;
            // Read data leave one enabled cycle after the load
            data_oe_n <= ~(p1_v_q & ~p1_w_q);
            if (p1_v_q && !p1_w_q) begin
                data_out <= mem[p1_a_q[7:0]];
            end
            // Stage 3 waits one edge for the word pushed at stage 2
            p3_v_q  <= p2_v_q;
            p3_w_q  <= p2_w_q;
            p3_a_q  <= p2_a_q;
            p3_bw_q <= p2_bw_q;
            p3_d_q  <= d_q;
            mem_write      <= p3_v_q & p3_w_q;
            mem_addr       <= p3_a_q;
            mem_wdata      <= wdat;
            mem_lane_write <= (p3_v_q & p3_w_q) ? ~p3_bw_q : 4'h0;
            // Registered ready lags the FIFO count by one edge
            wdata_ready    <= fifo_ready_w;
        end
    end
endmodule

//--- testbench/burst_sram_access_monitor.sv
// Port checker for the burst SRAM access block
`timescale 1ns/1ps
`include "burst_sram_consts.vh"
module burst_sram_access_monitor (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic               clock_suspend_n,
    input wire logic               advance_or_load_select,
    input wire logic               read_write_n,
    input wire logic               chip_select_first_n,
    input wire logic               chip_select_second_n,
    input wire logic               chip_select_positive,
    input wire logic               burst_order_select,
    input wire logic [`DATA_W-1:0] data_out,
    input wire logic               data_oe_n,
    input wire logic               mem_write,
    input wire logic [`ADDR_W-1:0] mem_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire sel = !chip_select_first_n && !chip_select_second_n && chip_select_positive;
    wire go  = !clock_suspend_n && !advance_or_load_select;
    wire rd  = go && sel && read_write_n;
    wire adv = !clock_suspend_n && advance_or_load_select;
    property p_rst; $rose(rst_n) |-> data_oe_n && !mem_write; endproperty
    a_rst: assert property (p_rst) else $error("bus busy after reset");
    property p_hold_q; clock_suspend_n [*3] |=> $stable(data_out) && $stable(data_oe_n); endproperty
    a_hold_q: assert property (p_hold_q) else $error("read side moved");
    property p_hold_m; clock_suspend_n [*3] |=> $stable(mem_write) && $stable(mem_addr); endproperty
    a_hold_m: assert property (p_hold_m) else $error("write side moved");
    property p_desel; (go && !sel) [*7] |-> data_oe_n; endproperty
    a_desel: assert property (p_desel) else $error("bus driven deselected");
    property p_rd; rd |-> ##[4:6] !data_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("read data missing");
    property p_wr; (go && sel && !read_write_n) ##1 adv [*3] |-> ##3 data_oe_n; endproperty
    a_wr: assert property (p_wr) else $error("bus driven in write");
    property p_dir; rd ##1 (adv && !read_write_n) [*3] |-> ##3 !data_oe_n; endproperty
    a_dir: assert property (p_dir) else $error("burst turned round");
    property p_step;
        mem_write && $past(mem_write) && mem_addr[16:2] == $past(mem_addr[16:2]) |->
            (burst_order_select ? mem_addr[0] != $past(mem_addr[0])
                                : mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1);
    endproperty
    a_step: assert property (p_step) else $error("bad burst order");
    c_rd: cover property (rd ##5 !data_oe_n);
    c_wr: cover property (mem_write ##1 mem_write);
    c_sus: cover property (clock_suspend_n && !data_oe_n);
endmodule
bind burst_sram_access burst_sram_access_monitor i_mon (.sys_clk, .rst_n, .clock_suspend_n,
    .advance_or_load_select, .read_write_n, .chip_select_first_n, .chip_select_second_n,
    .chip_select_positive, .burst_order_select, .data_out, .data_oe_n, .mem_write, .mem_addr);

//--- testbench/wdata_feeder.sv
// Controller write data model
`timescale 1ns/1ps
module wdata_feeder (
    input  wire logic        sys_clk,
    input  wire logic        send,
    input  wire logic [35:0] word,
    output logic             wdata_valid = 1'b0,
    output logic [35:0]      data_in = 36'h0_0000_0000
);
    logic [35:0] w_q;
    logic        v_q = 1'b0;
    // Data land one edge after lanes are taken, idle bus toggles
    always @(posedge sys_clk) begin
        v_q <= send;
        w_q <= word;
        wdata_valid <= v_q;
        data_in <= v_q ? w_q : ~data_in;
    end
endmodule

//--- testbench/test_burst_sram_access.sv
// Self-checking bench for the burst SRAM access block
`timescale 1ns/1ps
`include "burst_sram_consts.vh"
module test_burst_sram_access;
    logic               sys_clk = 0, rst_n = 0, clock_suspend_n = 0;
    logic               advance_or_load_select = 0, read_write_n = 1;
    logic               chip_select_first_n = 1, chip_select_second_n = 0;
    logic               chip_select_positive = 1, burst_order_select = 0;
    logic               send = 0, inv = 0, wdata_valid, wdata_ready, data_oe_n, mem_write;
    logic [`ADDR_W-1:0] address = 0, mem_addr, p_addr = 17'h1_FFFF;
    logic [`LANES-1:0]  byte_lane_write_n = 4'hF, mem_lane_write, p_mask = 0;
    logic [`DATA_W-1:0] data_in, data_out, mem_wdata, word = 0;
    int                 num_errors = 0, checks = 0, cyc = 0;
    burst_sram_access i_dut (.sys_clk, .rst_n, .clock_suspend_n, .advance_or_load_select,
        .read_write_n, .chip_select_first_n, .chip_select_second_n, .chip_select_positive,
        .burst_order_select, .address, .byte_lane_write_n, .data_in, .wdata_valid,
        .wdata_ready, .data_out, .data_oe_n, .mem_write, .mem_addr, .mem_wdata, .mem_lane_write);
    wdata_feeder i_feed (.sys_clk, .send, .word, .wdata_valid, .data_in);
    initial forever #5 sys_clk = ~sys_clk;
    // Ceiling well above the fewer than 200 cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report;
        end
    end
    task final_report;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [35:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [35:0] wd(input logic [16:0] a);
        wd = {2'h0, a, ~a};
    endfunction
    // Expected word, with the one lane-masked overwrite folded in
    function automatic logic [35:0] ev(input logic [16:0] a);
        ev = wd(a) ^ ((a == p_addr) ? {{9{p_mask[3]}}, {9{p_mask[2]}}, {9{p_mask[1]}},
            {9{p_mask[0]}}} : 36'h0_0000_0000);
    endfunction
    function automatic logic [16:0] bt(input logic [16:0] b, input logic o, input int i);
        bt = {b[16:2], o ? b[1:0] ^ i[1:0] : b[1:0] + i[1:0]};
    endfunction
    task step(input logic ld, rwn, s, input logic [16:0] a, input logic [3:0] ln, input logic sd);
        advance_or_load_select <= !ld;
        read_write_n <= rwn;
        chip_select_first_n <= !s;
        address <= a;
        byte_lane_write_n <= ln;
        send <= sd;
        word <= wd(a) ^ {36{inv}};
        @(posedge sys_clk);
    endtask
    task idle;
        step(1, 1, 0, 17'h0_0000, 4'hF, 0);
    endtask
    task wburst(input logic [16:0] b, input logic o, input logic sd);
        burst_order_select <= o;
        for (int i = 0; i < 4; i++) step(i == 0, i != 0, 1, bt(b, o, i), 4'h0, sd);
        repeat (6) idle;
    endtask
    task rburst(input logic [16:0] b, input logic o, hold, rwa);
        int n;
        logic [35:0] v;
        n = 0;
        burst_order_select <= o;
        for (int i = 0; i < 4; i++) step(i == 0, i == 0 ? 1'b1 : rwa, 1, bt(b, o, i), 4'hF, 0);
        #1;
        while (data_oe_n !== 1'b0 && n < 8) begin
            idle;
            #1;
            n++;
        end
        for (int i = 0; i < 4; i++) begin
            chk(data_out, ev(bt(b, o, i)));
            if (hold) begin
                clock_suspend_n <= 1;
                repeat (2) idle;
                #1 v = data_out;
                repeat (3) idle;
                #1 chk(data_out, v);
                chk(v, ev(bt(b, o, 2)));
                clock_suspend_n <= 0;
                repeat (8) idle;
                break;
            end
            idle;
            #1;
        end
        if (!hold) chk(data_oe_n, 1);
    endtask
    task t_burst;
        wburst(17'h0_0012, 0, 1);
        wburst(17'h0_0021, 1, 1);
        rburst(17'h0_0012, 0, 0, 1);
        rburst(17'h0_0021, 1, 0, 1);
        rburst(17'h0_0023, 1, 0, 0);
        rburst(17'h0_0023, 1, 0, 1);
        $display("burst test done");
    endtask
    task t_lanes;
        inv = 1;
        step(1, 0, 1, 17'h0_0012, 4'b1010, 1);
        inv = 0;
        p_addr = 17'h0_0012;
        p_mask = 4'b0101;
        repeat (5) idle;
        #1 chk(mem_write, 1);
        chk(mem_addr, 17'h0_0012);
        chk(mem_lane_write, 4'b0101);
        chk(mem_wdata, ~wd(17'h0_0012));
        rburst(17'h0_0010, 0, 0, 1);
        $display("lane test done");
    endtask
    task t_deselect;
        for (int k = 0; k < 3; k++) begin
            chip_select_second_n <= (k == 1);
            chip_select_positive <= (k != 2);
            repeat (8) step(1, 1, k != 0, 17'h0_0010, 4'hF, 0);
            #1 chk(data_oe_n, 1);
        end
        chip_select_second_n <= 0;
        chip_select_positive <= 1;
        idle;
        $display("deselect test done");
    endtask
    task t_fill;
        repeat (16) step(1, 1, 0, 17'h0_0000, 4'hF, 1);
        repeat (5) idle;
        #1 chk(wdata_ready, 0);
        for (int j = 0; j < 4; j++) wburst({13'h0010, j[1:0], 2'h0}, 0, 0);
        #1 chk(wdata_ready, 1);
        $display("fifo test done");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1;
        idle;
        t_burst;
        t_lanes;
        rburst(17'h0_0021, 1, 1, 1);
        $display("suspend test done");
        t_deselect;
        t_fill;
        final_report;
    end
endmodule
